/* File: hdl/dcsrm_consts.vh */
// Constants for the dual channel serial register map.
// Assumes inclusion by bare name from the register map modules.
// Summary of operation
// - A reserved bit that has storage keeps what the host writes and reads it back.
// - A reserved bit with no storage always reads as zero.
// - The master interrupt and reset register is one register written alike from either channel.
// - The interrupt vector is one location shared by both channels and writable from either.
// - Vector reads through channel B carry interrupt status, reads through channel A the plain value.
// - Channel A alone has a read-only register holding the pending bits of both channels.
// - With extended read on, receive, mode, transmit and misc control settings read at 9, 4, 5 and 11.
// - With extended read on, address 14 reads the extended feature register.
// - Addresses 6 and 7 give the frame byte count only while the frame FIFO is on in bit framing mode.
// - Addresses 12 and 13 read back the baud time constant low and high bytes.
// - The two bus variants differ in where each access takes its address: the address pins, or the command pointer and data select.
// - On the non-multiplexed variant the low three command bits point at registers 0 to 7.
// - Command code 001 adds eight to the pointer written with it.
`ifndef DCSRM_CONSTS_VH
`define DCSRM_CONSTS_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define DCSRM_A_CMD 4'h0
`define DCSRM_A_VEC 4'h2
`define DCSRM_A_PEND 4'h3
`define DCSRM_A_MODE 4'h4
`define DCSRM_A_TXP 4'h5
`define DCSRM_A_CNTL 4'h6
`define DCSRM_A_CNTH 4'h7
`define DCSRM_A_DATA 4'h8
`define DCSRM_A_MASTER 4'h9
`define DCSRM_A_RXP_RD 4'h9
`define DCSRM_A_RXP 4'h3
`define DCSRM_A_STAT10 4'hA
`define DCSRM_A_MISC 4'hA
`define DCSRM_A_MISC_RD 4'hB
`define DCSRM_A_BAUDL 4'hC
`define DCSRM_A_BAUDH 4'hD
`define DCSRM_A_EXT_RD 4'hE
`define DCSRM_A_STAT15 4'hF
`define DCSRM_A_STAT1 4'h1

// ----------------------------------------
// Fields and codes
// ----------------------------------------
`define DCSRM_CMD_LO 3
`define DCSRM_CMD_HI 5
`define DCSRM_PTR_HI 2
`define DCSRM_CMD_POINT_HIGH 3'h1
`define DCSRM_HIGH_BANK 1'h1
`define DCSRM_EXT_READ_BIT 6
`define DCSRM_NEW_REG_BIT 0
`define DCSRM_FIFO_EN_BIT 2
`define DCSRM_FRAMING_LO 4
`define DCSRM_FRAMING_HI 5
`define DCSRM_FRAMING_BIT 2'h2
`define DCSRM_RST_LO 6
`define DCSRM_RST_HI 7
`define DCSRM_RST_HW 2'h3
`define DCSRM_RST_A 2'h2
`define DCSRM_RST_B 2'h1
`define DCSRM_VEC_LO 1
`define DCSRM_VEC_HI 3

// ----------------------------------------
// Reset values and storage masks
// ----------------------------------------
`define DCSRM_RST_VAL 8'h00
`define DCSRM_PTR_RST 4'h0
`define DCSRM_MASK_FULL 8'hFF
`define DCSRM_MASK_EXT 8'h7F
`define DCSRM_MASK_STAT15 8'hFD
`define DCSRM_PEND_ZERO 2'h0

`endif

/* File: hdl/dcsrm_chan_regs.v */
// One channel's private write registers and its read-back multiplexer.
// Assumes writes arrive as one-cycle strobes already decoded by the top.
`timescale 1ns/10ps
module dcsrm_chan_regs (
  input wire core_clk,
  input wire nrst,
  input wire soft_rst,
  input wire wr_en,
  input wire [3:0] wr_addr,
  input wire [7:0] wr_data,
  input wire [3:0] rd_addr,
  input wire [7:0] stat0,
  input wire [7:0] stat1,
  input wire [7:0] stat10,
  input wire [7:0] rx_data,
  input wire [7:0] frame_cnt_low,
  input wire [7:0] frame_cnt_high,
  output reg [7:0] rd_data,
  output wire [15:0] baud_const,
  output wire [7:0] mode
);
`include "dcsrm_consts.vh"

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg [7:0] wreg [0:15];
  reg [7:0] ext_feat_r;
  wire new_reg_sel;
  wire ext_rd;
  wire fifo_on;
  integer i;

  // Bits without storage are cut at write time so they read zero
  function [7:0] store_mask;
    input [3:0] a;
    begin
      if (a == `DCSRM_A_STAT15)
        store_mask = `DCSRM_MASK_STAT15;
      else
        store_mask = `DCSRM_MASK_FULL;
    end
  endfunction

  assign new_reg_sel = wreg[`DCSRM_A_STAT15][`DCSRM_NEW_REG_BIT];
  assign ext_rd = ext_feat_r[`DCSRM_EXT_READ_BIT];
  assign fifo_on = wreg[`DCSRM_A_STAT15][`DCSRM_FIFO_EN_BIT] &&
                   (wreg[`DCSRM_A_MODE][`DCSRM_FRAMING_HI:`DCSRM_FRAMING_LO] == `DCSRM_FRAMING_BIT);
  assign baud_const = {wreg[`DCSRM_A_BAUDH], wreg[`DCSRM_A_BAUDL]};
  assign mode = wreg[`DCSRM_A_MODE];

  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (i = 0; i < 16; i = i + 1)
        wreg[i] <= `DCSRM_RST_VAL;
      ext_feat_r <= `DCSRM_RST_VAL;
    end
    else if (soft_rst)
    begin
      for (i = 0; i < 16; i = i + 1)
        wreg[i] <= `DCSRM_RST_VAL;
      ext_feat_r <= `DCSRM_RST_VAL;
    end
    else if (wr_en)
    begin
      // Address 7 is redirected to the feature register when opened
      if (wr_addr == `DCSRM_A_CNTH && new_reg_sel)
        ext_feat_r <= wr_data & `DCSRM_MASK_EXT;
      else
        wreg[wr_addr] <= wr_data & store_mask(wr_addr);
    end
  end

  // ----------------------------------------
  // Read-back
  // ----------------------------------------
  always @*
  begin
    rd_data = `DCSRM_RST_VAL;
    if (rd_addr == `DCSRM_A_CMD)
      rd_data = stat0;
    else if (rd_addr == `DCSRM_A_STAT1)
      rd_data = stat1;
    else if (rd_addr == `DCSRM_A_MODE)
      rd_data = ext_rd ? wreg[`DCSRM_A_MODE] : stat0;
    else if (rd_addr == `DCSRM_A_TXP)
      rd_data = ext_rd ? wreg[`DCSRM_A_TXP] : stat1;
    else if (rd_addr == `DCSRM_A_CNTL)
      rd_data = fifo_on ? frame_cnt_low : `DCSRM_RST_VAL;
    else if (rd_addr == `DCSRM_A_CNTH)
      rd_data = fifo_on ? frame_cnt_high : `DCSRM_RST_VAL;
    else if (rd_addr == `DCSRM_A_DATA)
      rd_data = rx_data;
    else if (rd_addr == `DCSRM_A_RXP_RD)
      rd_data = ext_rd ? wreg[`DCSRM_A_RXP] : wreg[`DCSRM_A_BAUDH];
    else if (rd_addr == `DCSRM_A_STAT10)
      rd_data = stat10;
    else if (rd_addr == `DCSRM_A_MISC_RD)
      rd_data = ext_rd ? wreg[`DCSRM_A_MISC] : wreg[`DCSRM_A_STAT15];
    else if (rd_addr == `DCSRM_A_BAUDL)
      rd_data = wreg[`DCSRM_A_BAUDL];
    else if (rd_addr == `DCSRM_A_BAUDH)
      rd_data = wreg[`DCSRM_A_BAUDH];
    else if (rd_addr == `DCSRM_A_EXT_RD)
      rd_data = ext_rd ? ext_feat_r : stat10;
    else if (rd_addr == `DCSRM_A_STAT15)
      rd_data = wreg[`DCSRM_A_STAT15];
  end

endmodule

/* File: hdl/dcsrm_top.v */
// Host-facing register map of a two-channel serial controller.
// Assumes asynchronous host strobes on pins; status comes from logic on core_clk.
`timescale 1ns/10ps
module dcsrm_top (
  input wire core_clk,
  input wire nrst,
  input wire mux_bus_mode,
  input wire cs_n,
  input wire rd_n,
  input wire wr_n,
  input wire chan_a_sel,
  input wire data_sel,
  input wire [3:0] addr_in,
  input wire [7:0] data_in,
  output reg [7:0] data_out,
  output reg data_oe,
  input wire [7:0] stat0_a,
  input wire [7:0] stat0_b,
  input wire [7:0] stat1_a,
  input wire [7:0] stat1_b,
  input wire [7:0] stat10_a,
  input wire [7:0] stat10_b,
  input wire [7:0] rx_data_a,
  input wire [7:0] rx_data_b,
  input wire [7:0] frame_cnt_low_a,
  input wire [7:0] frame_cnt_low_b,
  input wire [7:0] frame_cnt_high_a,
  input wire [7:0] frame_cnt_high_b,
  input wire [2:0] pending_a,
  input wire [2:0] pending_b,
  input wire [2:0] vec_status,
  output reg [7:0] tx_data,
  output reg tx_load_a,
  output reg tx_load_b,
  output reg [7:0] master_irq_reset_reg,
  output reg [7:0] shared_vector_reg,
  output reg [15:0] baud_a,
  output reg [15:0] baud_b,
  output reg [7:0] mode_a,
  output reg [7:0] mode_b
);
`include "dcsrm_consts.vh"

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Stage one is read only by stage two
  reg [17:0] pin_s1_r;
  reg [17:0] pin_s2_r;
  wire [17:0] pin_raw;
  wire cs_s;
  wire rd_s;
  wire wr_s;
  wire chan_a_s;
  wire data_sel_s;
  wire [3:0] addr_s;
  wire [7:0] din_s;

  assign pin_raw = {~cs_n, ~rd_n, ~wr_n, chan_a_sel, data_sel, addr_in, data_in, mux_bus_mode};

  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_s1_r <= 18'h00000;
      pin_s2_r <= 18'h00000;
    end
    else
    begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
    end
  end

  assign cs_s = pin_s2_r[17];
  assign rd_s = pin_s2_r[16];
  assign wr_s = pin_s2_r[15];
  assign chan_a_s = pin_s2_r[14];
  assign data_sel_s = pin_s2_r[13];
  assign addr_s = pin_s2_r[12:9];
  assign din_s = pin_s2_r[8:1];

  // ----------------------------------------
  // Strobe edges
  // ----------------------------------------
  // Writes are taken at strobe release so data has settled for two cycles
  reg wr_act_r;
  reg rd_act_r;
  reg mux_mode_r;
  wire wr_done;
  wire rd_done;
  wire rd_act;

  assign rd_act = cs_s && rd_s;
  assign wr_done = wr_act_r && !(cs_s && wr_s);
  assign rd_done = rd_act_r && !rd_act;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  reg [3:0] ptr_r;
  reg [3:0] ptr_nxt;
  reg [3:0] wr_addr_r;
  reg wr_chan_a_r;
  reg [7:0] wr_data_r;
  wire [3:0] acc_addr;
  wire cmd_acc;
  wire wr_a;
  wire wr_b;
  wire [7:0] rd_a;
  wire [7:0] rd_b;
  wire [15:0] baud_a_w;
  wire [15:0] baud_b_w;
  wire [7:0] mode_a_w;
  wire [7:0] mode_b_w;
  reg soft_rst_a_r;
  reg soft_rst_b_r;
  reg wr_pend_r;

  // The bus variants differ in every access address: the pins, or data select and the command pointer
  assign acc_addr = mux_mode_r ? addr_s : (data_sel_s ? `DCSRM_A_DATA : ptr_r);
  assign cmd_acc = (acc_addr == `DCSRM_A_CMD);

  always @*
  begin
    ptr_nxt = ptr_r;
    if (wr_done && !mux_mode_r && !data_sel_s && cmd_acc)
    begin
      ptr_nxt = {(wr_data_r[`DCSRM_CMD_HI:`DCSRM_CMD_LO] == `DCSRM_CMD_POINT_HIGH),
                 wr_data_r[`DCSRM_PTR_HI:0]};
    end
    else if ((wr_done || rd_done) && !data_sel_s)
    begin
      ptr_nxt = `DCSRM_PTR_RST;
    end
  end

  // Private writes go to the selected channel only
  assign wr_a = wr_pend_r && wr_chan_a_r;
  assign wr_b = wr_pend_r && !wr_chan_a_r;

  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_act_r <= 1'b0;
      rd_act_r <= 1'b0;
      mux_mode_r <= 1'b0;
      ptr_r <= `DCSRM_PTR_RST;
      wr_addr_r <= `DCSRM_PTR_RST;
      wr_chan_a_r <= 1'b0;
      wr_data_r <= `DCSRM_RST_VAL;
      wr_pend_r <= 1'b0;
      master_irq_reset_reg <= `DCSRM_RST_VAL;
      shared_vector_reg <= `DCSRM_RST_VAL;
      soft_rst_a_r <= 1'b0;
      soft_rst_b_r <= 1'b0;
      tx_data <= `DCSRM_RST_VAL;
      tx_load_a <= 1'b0;
      tx_load_b <= 1'b0;
    end
    else
    begin
      wr_act_r <= cs_s && wr_s;
      rd_act_r <= rd_act;
      mux_mode_r <= pin_s2_r[0];
      ptr_r <= ptr_nxt;
      wr_data_r <= din_s;
      wr_pend_r <= 1'b0;
      soft_rst_a_r <= 1'b0;
      soft_rst_b_r <= 1'b0;
      tx_load_a <= 1'b0;
      tx_load_b <= 1'b0;
      if (wr_done)
      begin
        wr_addr_r <= acc_addr;
        wr_chan_a_r <= chan_a_s;
        if (acc_addr == `DCSRM_A_MASTER)
        begin
          master_irq_reset_reg <= wr_data_r;
          soft_rst_a_r <= (wr_data_r[`DCSRM_RST_HI:`DCSRM_RST_LO] == `DCSRM_RST_HW) ||
                          (wr_data_r[`DCSRM_RST_HI:`DCSRM_RST_LO] == `DCSRM_RST_A);
          soft_rst_b_r <= (wr_data_r[`DCSRM_RST_HI:`DCSRM_RST_LO] == `DCSRM_RST_HW) ||
                          (wr_data_r[`DCSRM_RST_HI:`DCSRM_RST_LO] == `DCSRM_RST_B);
        end
        else if (acc_addr == `DCSRM_A_VEC)
          shared_vector_reg <= wr_data_r;
        else if (acc_addr == `DCSRM_A_DATA)
        begin
          tx_data <= wr_data_r;
          tx_load_a <= chan_a_s;
          tx_load_b <= !chan_a_s;
        end
        else if (!cmd_acc || mux_mode_r)
          wr_pend_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Channel register sets
  // ----------------------------------------
  dcsrm_chan_regs u_chan_a (
    .core_clk(core_clk),
    .nrst(nrst),
    .soft_rst(soft_rst_a_r),
    .wr_en(wr_a),
    .wr_addr(wr_addr_r),
    .wr_data(wr_data_r),
    .rd_addr(acc_addr),
    .stat0(stat0_a),
    .stat1(stat1_a),
    .stat10(stat10_a),
    .rx_data(rx_data_a),
    .frame_cnt_low(frame_cnt_low_a),
    .frame_cnt_high(frame_cnt_high_a),
    .rd_data(rd_a),
    .baud_const(baud_a_w),
    .mode(mode_a_w)
  );

  dcsrm_chan_regs u_chan_b (
    .core_clk(core_clk),
    .nrst(nrst),
    .soft_rst(soft_rst_b_r),
    .wr_en(wr_b),
    .wr_addr(wr_addr_r),
    .wr_data(wr_data_r),
    .rd_addr(acc_addr),
    .stat0(stat0_b),
    .stat1(stat1_b),
    .stat10(stat10_b),
    .rx_data(rx_data_b),
    .frame_cnt_low(frame_cnt_low_b),
    .frame_cnt_high(frame_cnt_high_b),
    .rd_data(rd_b),
    .baud_const(baud_b_w),
    .mode(mode_b_w)
  );

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  reg [7:0] rd_mux;

  always @*
  begin
    rd_mux = chan_a_s ? rd_a : rd_b;
    if (acc_addr == `DCSRM_A_VEC)
    begin
      rd_mux = shared_vector_reg;
      if (!chan_a_s)
        rd_mux[`DCSRM_VEC_HI:`DCSRM_VEC_LO] = vec_status;
    end
    else if (acc_addr == `DCSRM_A_PEND)
      rd_mux = chan_a_s ? {`DCSRM_PEND_ZERO, pending_a, pending_b} : `DCSRM_RST_VAL;
  end

  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      data_out <= `DCSRM_RST_VAL;
      data_oe <= 1'b0;
      baud_a <= 16'h0000;
      baud_b <= 16'h0000;
      mode_a <= `DCSRM_RST_VAL;
      mode_b <= `DCSRM_RST_VAL;
    end
    else
    begin
      data_oe <= rd_act;
      data_out <= rd_act ? rd_mux : `DCSRM_RST_VAL;
      baud_a <= baud_a_w;
      baud_b <= baud_b_w;
      mode_a <= mode_a_w;
      mode_b <= mode_b_w;
    end
  end

endmodule

/* File: sim/dcsrm_chk_asserts.sv */
// Checker for the register map's pin-level read and write behaviour.
// Assumes it is bound to dcsrm_top and that the host holds its pins steady per access.
`timescale 1ns/10ps
module dcsrm_chk (
  input logic core_clk,
  input logic nrst,
  input logic mux_bus_mode,
  input logic cs_n,
  input logic rd_n,
  input logic wr_n,
  input logic chan_a_sel,
  input logic [3:0] addr_in,
  input logic [7:0] data_out,
  input logic data_oe,
  input logic [2:0] pending_a,
  input logic [2:0] pending_b,
  input logic [2:0] vec_status,
  input logic tx_load_a,
  input logic tx_load_b,
  input logic [7:0] master_irq_reset_reg,
  input logic [7:0] shared_vector_reg,
  input logic [15:0] baud_a
);
  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  wire rd_req = !cs_n && !rd_n;
  wire rd_on = rd_req && mux_bus_mode;
  reg [3:0] since_wr_r;
  // Saturates so a long idle spell never wraps back into the window
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      since_wr_r <= 4'hF;
    else if (!wr_n)
      since_wr_r <= 4'h0;
    else if (since_wr_r != 4'hF)
      since_wr_r <= since_wr_r + 4'h1;
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_oe_quiet: assert property (!data_oe |-> data_out == 8'h00)
    else $error("data_out not zero while idle");
  a_oe_cause: assert property ($rose(data_oe) |-> $past(rd_req, 2))
    else $error("data_oe rose without a read strobe");
  a_read_answer: assert property (rd_req [*5] |-> data_oe)
    else $error("read got no answer");
  a_oe_release: assert property ($rose(rd_n) |-> ##[1:5] !data_oe)
    else $error("data_oe held after read release");
  a_load_pulse: assert property (tx_load_a |=> !tx_load_a)
    else $error("tx_load_a longer than one cycle");
  a_load_chan: assert property (tx_load_a |-> chan_a_sel && !tx_load_b)
    else $error("tx load on wrong channel");
  a_load_chan_b: assert property (tx_load_b |-> !chan_a_sel && !tx_load_a)
    else $error("tx load on wrong channel B");
  a_shared_cause: assert property ($changed(master_irq_reset_reg) || $changed(shared_vector_reg) |-> since_wr_r < 4'hA)
    else $error("shared register changed without a write");
  a_vec_plain: assert property ((rd_on && chan_a_sel && addr_in == 4'h2) [*5] |-> data_out == shared_vector_reg)
    else $error("channel A vector read modified");
  a_vec_status: assert property ((rd_on && !chan_a_sel && addr_in == 4'h2) [*5] |-> data_out[3:1] == $past(vec_status))
    else $error("channel B vector lacks status");
  a_pend_a: assert property ((rd_on && chan_a_sel && addr_in == 4'h3) [*5] |-> data_out == {2'b00, $past(pending_a), $past(pending_b)})
    else $error("pending bits read wrong");
  a_pend_b: assert property ((rd_on && !chan_a_sel && addr_in == 4'h3) [*5] |-> data_out == 8'h00)
    else $error("channel B pending read not zero");
  a_baud_rd: assert property ((rd_on && chan_a_sel && addr_in == 4'hC) [*5] |-> data_out == baud_a[7:0])
    else $error("baud low read wrong");

  c_vec_b: cover property ((rd_on && !chan_a_sel && addr_in == 4'h2) [*5]);
  c_load_b: cover property (tx_load_b);
  c_baud_clear: cover property ($fell(baud_a != 16'h0000));
endmodule

/* File: sim/dcsrm_host.sv */
// Host processor model driving the register map's strobes and data pins.
// Assumes one access at a time, called from the bench top.
`timescale 1ns/10ps
module dcsrm_host (
  input wire core_clk,
  input wire [7:0] data_out,
  output reg cs_n,
  output reg rd_n,
  output reg wr_n,
  output reg chan_a_sel,
  output reg data_sel,
  output reg [3:0] addr_in,
  output reg [7:0] data_in
);
  initial
  begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    chan_a_sel = 1'b1;
    data_sel = 1'b0;
    addr_in = 4'h0;
    data_in = 8'hFF;
  end

  // ----------------------------------------
  // One strobed access, write or read
  // ----------------------------------------
  // Caller supplies only assigned codes; reserved bits may be written as ones
  task acc(input ch, input ds, input [3:0] a, input wr, input [7:0] d, output [7:0] q);
    begin
      @(posedge core_clk);
      chan_a_sel <= ch;
      data_sel <= ds;
      addr_in <= a;
      data_in <= d;
      cs_n <= 1'b0;
      wr_n <= ~wr;
      rd_n <= wr;
      repeat (6) @(posedge core_clk);
      #1 q = data_out;
      @(posedge core_clk);
      cs_n <= 1'b1;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      // Data outlives the strobe since the write lands after synchronising
      repeat (4) @(posedge core_clk);
      data_in <= ~d;
      repeat (4) @(posedge core_clk);
    end
  endtask
endmodule

/* File: sim/dcsrm_top_tb_top.sv */
// Self-checking bench for the register map, host model on the pins.
// Assumes status inputs are held steady by the bench during reads.
`timescale 1ns/10ps
module dcsrm_top_tb_top;
  reg core_clk = 1'b0;
  reg nrst = 1'b0;
  reg mux = 1'b1;
  reg [2:0] pa = 3'h5;
  reg [2:0] pb = 3'h3;
  reg [2:0] vs = 3'h7;
  reg [7:0] sv [0:11];
  reg [7:0] q;
  integer err_count = 0;
  integer n_tests = 0;
  integer i;
  wire cs_n, rd_n, wr_n, chan_a_sel, data_sel, data_oe, tx_load_a, tx_load_b;
  wire [3:0] addr_in;
  wire [7:0] data_in, data_out, tx_data, mreg, vreg, mode_a, mode_b;
  wire [15:0] baud_a, baud_b;

  initial
  begin
    forever #2 core_clk = ~core_clk;
  end

  dcsrm_host dcsrm_host_i (.core_clk(core_clk), .data_out(data_out), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .chan_a_sel(chan_a_sel), .data_sel(data_sel), .addr_in(addr_in), .data_in(data_in));

  dcsrm_top dcsrm_top_i (.core_clk(core_clk), .nrst(nrst), .mux_bus_mode(mux), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .chan_a_sel(chan_a_sel), .data_sel(data_sel), .addr_in(addr_in), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .stat0_a(sv[0]), .stat0_b(sv[1]), .stat1_a(sv[2]),
    .stat1_b(sv[3]), .stat10_a(sv[4]), .stat10_b(sv[5]), .rx_data_a(sv[6]), .rx_data_b(sv[7]),
    .frame_cnt_low_a(sv[8]), .frame_cnt_low_b(sv[9]), .frame_cnt_high_a(sv[10]), .frame_cnt_high_b(sv[11]),
    .pending_a(pa), .pending_b(pb), .vec_status(vs), .tx_data(tx_data), .tx_load_a(tx_load_a),
    .tx_load_b(tx_load_b), .master_irq_reset_reg(mreg), .shared_vector_reg(vreg), .baud_a(baud_a),
    .baud_b(baud_b), .mode_a(mode_a), .mode_b(mode_b));

  // ----------------------------------------
  // Compare and verdict
  // ----------------------------------------
  task check(input [15:0] seen, input [15:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp)
      begin
        err_count = err_count + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task conclude;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_count = err_count + 1;
    conclude;
  end

  initial
  begin
    for (i = 0; i < 12; i = i + 1)
      sv[i] = {i[3:0], 4'h9};
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    dcsrm_host_i.acc(1, 0, 4'hC, 0, 8'h00, q);
    check(q, 16'h0000);
    dcsrm_host_i.acc(1, 0, 4'hC, 1, 8'h34, q);
    dcsrm_host_i.acc(1, 0, 4'hD, 1, 8'h12, q);
    dcsrm_host_i.acc(0, 0, 4'hC, 1, 8'h56, q);
    dcsrm_host_i.acc(1, 0, 4'hC, 0, 8'h00, q);
    check(q, 16'h0034);
    dcsrm_host_i.acc(1, 0, 4'hD, 0, 8'h00, q);
    check(q, 16'h0012);
    dcsrm_host_i.acc(0, 0, 4'hC, 0, 8'h00, q);
    check(q, 16'h0056);
    check(baud_a, 16'h1234);
    check(baud_b, 16'h0056);
    dcsrm_host_i.acc(0, 0, 4'h9, 1, 8'h05, q);
    check(mreg, 16'h0005);
    dcsrm_host_i.acc(1, 0, 4'h9, 1, 8'h0A, q);
    check(mreg, 16'h000A);
    dcsrm_host_i.acc(0, 0, 4'h2, 1, 8'hA5, q);
    check(vreg, 16'h00A5);
    dcsrm_host_i.acc(1, 0, 4'h2, 0, 8'h00, q);
    check(q, 16'h00A5);
    dcsrm_host_i.acc(0, 0, 4'h2, 0, 8'h00, q);
    check(q, 16'h00AF);
    dcsrm_host_i.acc(1, 0, 4'h3, 0, 8'h00, q);
    check(q, 16'h002B);
    dcsrm_host_i.acc(0, 0, 4'h3, 0, 8'h00, q);
    check(q, 16'h0000);
    // Deliberate ones in reserved bits to see which ones hold storage
    dcsrm_host_i.acc(1, 0, 4'hF, 1, 8'hFF, q);
    dcsrm_host_i.acc(1, 0, 4'hB, 0, 8'h00, q);
    check(q, 16'h00FD);
    dcsrm_host_i.acc(1, 0, 4'h6, 0, 8'h00, q);
    check(q, 16'h0000);
    dcsrm_host_i.acc(1, 0, 4'h4, 1, 8'h20, q);
    check(mode_a, 16'h0020);
    check(mode_b, 16'h0000);
    dcsrm_host_i.acc(1, 0, 4'h4, 0, 8'h00, q);
    check(q, {8'h00, sv[0]});
    dcsrm_host_i.acc(1, 0, 4'h5, 0, 8'h00, q);
    check(q, {8'h00, sv[2]});
    dcsrm_host_i.acc(1, 0, 4'h6, 0, 8'h00, q);
    check(q, {8'h00, sv[8]});
    dcsrm_host_i.acc(1, 0, 4'h7, 0, 8'h00, q);
    check(q, {8'h00, sv[10]});
    // Extended read: bit 7 of the feature byte has no storage
    dcsrm_host_i.acc(1, 0, 4'h3, 1, 8'h11, q);
    dcsrm_host_i.acc(1, 0, 4'hA, 1, 8'h22, q);
    dcsrm_host_i.acc(1, 0, 4'h7, 1, 8'hC0, q);
    dcsrm_host_i.acc(1, 0, 4'hE, 0, 8'h00, q);
    check(q, 16'h0040);
    dcsrm_host_i.acc(1, 0, 4'h4, 0, 8'h00, q);
    check(q, 16'h0020);
    dcsrm_host_i.acc(1, 0, 4'h5, 0, 8'h00, q);
    check(q, 16'h0000);
    dcsrm_host_i.acc(1, 0, 4'h9, 0, 8'h00, q);
    check(q, 16'h0011);
    dcsrm_host_i.acc(1, 0, 4'hB, 0, 8'h00, q);
    check(q, 16'h0022);
    dcsrm_host_i.acc(0, 0, 4'h8, 1, 8'h3C, q);
    check(tx_data, 16'h003C);
    dcsrm_host_i.acc(1, 0, 4'h9, 1, 8'h80, q);
    check(baud_a, 16'h0000);
    check(baud_b, 16'h0056);
    check(mreg, 16'h0080);
    check(vreg, 16'h00A5);
    mux <= 1'b0;
    dcsrm_host_i.acc(1, 0, 4'h0, 1, 8'h0C, q);
    dcsrm_host_i.acc(1, 0, 4'h0, 1, 8'h77, q);
    check(baud_a, 16'h0077);
    dcsrm_host_i.acc(0, 0, 4'h0, 1, 8'h02, q);
    dcsrm_host_i.acc(0, 0, 4'h0, 0, 8'h00, q);
    check(q, 16'h00AF);
    dcsrm_host_i.acc(1, 1, 4'h0, 0, 8'h00, q);
    check(q, {8'h00, sv[6]});
    dcsrm_host_i.acc(0, 1, 4'h0, 1, 8'h5A, q);
    check(tx_data, 16'h005A);
    dcsrm_host_i.acc(0, 0, 4'h0, 1, 8'h09, q);
    dcsrm_host_i.acc(0, 0, 4'h0, 1, 8'h40, q);
    check(mreg, 16'h0040);
    check(baud_b, 16'h0000);
    check(baud_a, 16'h0077);
    dcsrm_host_i.acc(1, 0, 4'h0, 1, 8'h09, q);
    dcsrm_host_i.acc(1, 0, 4'h0, 1, 8'hC0, q);
    check(mreg, 16'h00C0);
    check(baud_a, 16'h0000);
    conclude;
  end
endmodule

bind dcsrm_top dcsrm_chk dcsrm_chk_i (.core_clk(core_clk), .nrst(nrst), .mux_bus_mode(mux_bus_mode),
  .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .chan_a_sel(chan_a_sel), .addr_in(addr_in), .data_out(data_out),
  .data_oe(data_oe), .pending_a(pending_a), .pending_b(pending_b), .vec_status(vec_status),
  .tx_load_a(tx_load_a), .tx_load_b(tx_load_b), .master_irq_reset_reg(master_irq_reset_reg),
  .shared_vector_reg(shared_vector_reg), .baud_a(baud_a));
